// ===== logic/ipc_idle_gap.v
`timescale 1ns/1ps
`default_nettype none
`include "ipc_regs.vh"

// idle-gap counter between separate instructions
module ipc_idle_gap (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // control
    input wire start,
    input wire [`IPC_IDLE_W-1:0] count,
    output wire busy
);
    reg [`IPC_IDLE_W-1:0] remain;

    assign busy = (remain != 8'h00);

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            remain <= 8'h00;
        end else if (start) begin
            remain <= count;
        end else if (busy) begin
            remain <= remain - 8'h01;
        end
    end
endmodule
`default_nettype wire

// ===== logic/ipc_pipe.v
// Behaviour
// - each instruction passes decode, operand read, execute and, when needed, write-back, in order.
// - fetch opcode at segment:pointer when buses idle and fetch register empty.
// - decode decides operand need; start memory read when memory operand needed.
// - execute only with opcode and operand present; jump to matching microcode.
// - write result to memory only for instructions needing it.
// - with overlap on, next opcode fetch runs while current is executed.
// - configuration bit disables instruction overlap.
// - insert programmed idle cycles between execution of consecutive instructions.
// - no idle cycles between repeat-prefix iterations of one instruction.
`timescale 1ns/1ps
`default_nettype none
`include "ipc_regs.vh"

module ipc_pipe (
    // clock and reset
    input wire mclk,
    input wire resetn,
    // configuration
    input wire overlap_disable,
    input wire [`IPC_IDLE_W-1:0] idle_count,
    // system bus
    output reg bus_req,
    output reg [1:0] bus_kind,
    output reg [`IPC_ADDR_W-1:0] bus_addr,
    output reg [`IPC_DATA_W-1:0] bus_wdata,
    input wire bus_busy,
    input wire bus_done,
    input wire [`IPC_DATA_W-1:0] bus_rdata,
    // decoder info for the opcode under decode
    output reg [`IPC_OP_W-1:0] dec_opcode,
    input wire dec_need_mem,
    input wire [`IPC_ADDR_W-1:0] dec_mem_addr,
    input wire dec_need_write,
    input wire dec_repeat,
    // microcode engine
    output reg ucode_start,
    output reg [`IPC_OP_W-1:0] ucode_entry,
    output reg [`IPC_DATA_W-1:0] ucode_operand,
    input wire ucode_done,
    input wire [`IPC_DATA_W-1:0] ucode_result,
    input wire ucode_again,
    // status
    output reg [3:0] stage_busy
);
    localparam ST_IDLE = 2'h0;
    localparam ST_RD = 2'h1;
    localparam ST_EX = 2'h2;
    localparam ST_WR = 2'h3;

    reg [1:0] state;
    reg [15:0] code_seg;
    reg [15:0] ins_ptr;
    reg fetch_full;
    reg [`IPC_OP_W-1:0] fetch_op;
    reg need_write;
    reg [`IPC_ADDR_W-1:0] op_addr;
    reg is_repeat;
    reg gap_start;
    wire gap_busy;
    reg bus_active;
    reg [1:0] active_kind;

    function [`IPC_ADDR_W-1:0] phys;
        input [15:0] seg;
        input [15:0] off;
        begin
            phys = {seg, 4'h0} + {4'h0, off};
        end
    endfunction

    // no cycle of ours or of anyone else's on the bus
    function bus_free;
        input active;
        input busy;
        begin
            bus_free = !active && !busy;
        end
    endfunction

    // the active bus cycle of the wanted kind ends on this edge
    function cycle_end;
        input done;
        input active;
        input [1:0] kind_now;
        input [1:0] kind_want;
        begin
            cycle_end = done && active && (kind_now == kind_want);
        end
    endfunction

    ipc_idle_gap u_gap (
        .mclk(mclk),
        .resetn(resetn),
        .start(gap_start),
        .count(idle_count),
        .busy(gap_busy)
    );

    // decoder answers are same-clock logic, read without a synchroniser
    wire dec_need_mem_q = dec_need_mem;

    // overlap gating
    // the fetch stall keeps overlap off strictly serial, at a cost in throughput
    wire fetch_ok = !fetch_full && bus_free(bus_active, bus_busy) &&
                    (!overlap_disable || state == ST_IDLE);
    wire want_rd = (state == ST_RD) && bus_free(bus_active, bus_busy) && !bus_req;
    wire want_wr = (state == ST_WR) && bus_free(bus_active, bus_busy) && !bus_req;

    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            code_seg <= `IPC_RST_CS;
            ins_ptr <= `IPC_RST_IP;
            fetch_full <= 1'b0;
            fetch_op <= 8'h00;
            need_write <= 1'b0;
            op_addr <= 20'h00000;
            is_repeat <= 1'b0;
            gap_start <= 1'b0;
            bus_active <= 1'b0;
            active_kind <= `IPC_BUS_FETCH;
            bus_req <= 1'b0;
            bus_kind <= `IPC_BUS_FETCH;
            bus_addr <= 20'h00000;
            bus_wdata <= 16'h0000;
            dec_opcode <= 8'h00;
            ucode_start <= 1'b0;
            ucode_entry <= 8'h00;
            ucode_operand <= 16'h0000;
            stage_busy <= 4'h0;
        end else begin
            bus_req <= 1'b0;
            ucode_start <= 1'b0;
            gap_start <= 1'b0;
            if (bus_req) begin
                bus_active <= 1'b1;
            end
            // memory operand read and write-back take the bus first
            if (want_rd && dec_need_mem_q) begin
                bus_req <= 1'b1;
                bus_kind <= `IPC_BUS_READ;
                active_kind <= `IPC_BUS_READ;
                // op_addr is captured on every ST_RD edge, this one included
                bus_addr <= dec_mem_addr;
            end else if (want_wr) begin
                bus_req <= 1'b1;
                bus_kind <= `IPC_BUS_WRITE;
                active_kind <= `IPC_BUS_WRITE;
                bus_addr <= op_addr;
            end else if (fetch_ok && !bus_req) begin
                bus_req <= 1'b1;
                bus_kind <= `IPC_BUS_FETCH;
                active_kind <= `IPC_BUS_FETCH;
                bus_addr <= phys(code_seg, ins_ptr);
            end
            if (bus_done && bus_active) begin
                bus_active <= 1'b0;
                if (active_kind == `IPC_BUS_FETCH) begin
                    fetch_full <= 1'b1;
                    fetch_op <= bus_rdata[`IPC_OP_W-1:0];
                    ins_ptr <= ins_ptr + 16'h0001;
                end
            end
            case (state)
                ST_IDLE: begin
                    if (fetch_full && !gap_busy && !gap_start) begin
                        dec_opcode <= fetch_op;
                        fetch_full <= 1'b0;
                        state <= ST_RD;
                    end
                end
                ST_RD: begin
                    need_write <= dec_need_write;
                    op_addr <= dec_mem_addr;
                    is_repeat <= dec_repeat;
                    if (!dec_need_mem_q) begin
                        ucode_start <= 1'b1;
                        ucode_entry <= dec_opcode;
                        state <= ST_EX;
                    end else if (cycle_end(bus_done, bus_active, active_kind,
                                           `IPC_BUS_READ)) begin
                        ucode_operand <= bus_rdata;
                        ucode_start <= 1'b1;
                        ucode_entry <= dec_opcode;
                        state <= ST_EX;
                    end
                end
                ST_EX: begin
                    if (ucode_done) begin
                        bus_wdata <= ucode_result;
                        if (ucode_again && is_repeat) begin
                            ucode_start <= 1'b1;
                        end else if (need_write) begin
                            state <= ST_WR;
                        end else begin
                            gap_start <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_WR: begin
                    if (cycle_end(bus_done, bus_active, active_kind, `IPC_BUS_WRITE)) begin
                        gap_start <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
            stage_busy <= {state == ST_WR, state == ST_EX, state == ST_RD,
                           fetch_full | (bus_active & (active_kind == `IPC_BUS_FETCH))};
        end
    end
endmodule
`default_nettype wire

// ===== logic/ipc_regs.vh
`ifndef IPC_REGS_VH
`define IPC_REGS_VH

// configuration register indices (informational, no bus reaches them)
`define IPC_CFG_IDX_PERF 8'h0a
`define IPC_CFG_IDX_OVL 8'h0b
// field widths
`define IPC_ADDR_W 20
`define IPC_DATA_W 16
`define IPC_OP_W 8
`define IPC_IDLE_W 8
// bus cycle kinds
`define IPC_BUS_FETCH 2'h0
`define IPC_BUS_READ 2'h1
`define IPC_BUS_WRITE 2'h2
// reset values
`define IPC_RST_CS 16'hffff
`define IPC_RST_IP 16'h0000

`endif

// ===== tb/ipc_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipc_bus_model (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // request side
    input wire logic bus_req,
    input wire logic slow,
    input wire logic [19:0] bus_addr,
    // answer side
    output logic bus_done,
    output logic [15:0] bus_rdata
);
    int w;
    logic act;
    always @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            act <= 1'b0;
            bus_done <= 1'b0;
            w <= 0;
            bus_rdata <= 16'h0000;
        end else begin
            bus_done <= 1'b0;
            // one cycle at a time, opcode in low byte
            if (bus_req) begin
                act <= 1'b1;
                w <= slow ? 4 : 0;
            end else if (act && w > 0) w <= w - 1;
            else if (act) begin
                act <= 1'b0;
                bus_done <= 1'b1;
                bus_rdata <= {8'h00, bus_addr[7:0]};
            end else bus_rdata <= ~bus_rdata;
        end
    end
endmodule
`default_nettype wire

// ===== tb/ipc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module ipc_monitor (
    // clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // configuration and bus
    input wire logic overlap_disable,
    input wire logic bus_req,
    input wire logic bus_busy,
    input wire logic [1:0] bus_kind,
    input wire logic [19:0] bus_addr,
    // decode and microcode
    input wire logic ucode_start,
    input wire logic ucode_done,
    input wire logic ucode_again,
    input wire logic dec_repeat,
    input wire logic [7:0] ucode_entry,
    input wire logic [7:0] dec_opcode,
    // status
    input wire logic [3:0] stage_busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!resetn);
    chk_busy_holds: assert property ($past(bus_busy) |-> !bus_req)
        else $error("request while busy");
    chk_req_single: assert property (bus_req |=> !bus_req)
        else $error("request longer than a cycle");
    chk_addr_stands: assert property (!bus_req |-> $stable(bus_addr) && $stable(bus_kind))
        else $error("address moved");
    chk_start_single: assert property (ucode_start |=> !ucode_start)
        else $error("start longer than a cycle");
    chk_entry_match: assert property (ucode_start |-> ucode_entry == dec_opcode)
        else $error("wrong entry");
    chk_exec_flag: assert property (ucode_start |=> stage_busy[2])
        else $error("exec not flagged");
    chk_fetch_flag: assert property (bus_req && bus_kind == 2'h0 |-> ##2 stage_busy[0])
        else $error("fetch not flagged");
    chk_serial_fetch: assert property (overlap_disable && bus_req && bus_kind == 2'h0
        |-> stage_busy[3:1] == 3'h0)
        else $error("overlap while disabled");
    chk_repeat_nogap: assert property (ucode_done && ucode_again && dec_repeat
        |-> ##[1:3] ucode_start)
        else $error("repeat delayed");
    cover property (bus_req && bus_kind == 2'h2);
    cover property (ucode_done && ucode_again);
    cover property (bus_req && bus_kind == 2'h0 && stage_busy[2]);
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 0, resetn = 0, overlap_disable = 0, bus_busy = 0, slow = 0, rep, pend, saw;
    logic ucode_done, ucode_again, dec_need_mem, dec_need_write, dec_repeat;
    logic bus_req, bus_done, ucode_start;
    logic [1:0] bus_kind;
    logic [19:0] bus_addr, dec_mem_addr;
    logic [15:0] bus_wdata, bus_rdata, ucode_operand, ucode_result = 16'h0000;
    logic [7:0] idle_count = 8'h00, dec_opcode, ucode_entry, op;
    logic [3:0] stage_busy;
    int miscompares = 0, num_checks = 0, n_exec, gap, min_gap, uc;
    ipc_pipe uut (.mclk, .resetn, .overlap_disable, .idle_count, .bus_req, .bus_kind,
        .bus_addr, .bus_wdata, .bus_busy, .bus_done, .bus_rdata, .dec_opcode, .dec_need_mem,
        .dec_mem_addr, .dec_need_write, .dec_repeat, .ucode_start, .ucode_entry,
        .ucode_operand, .ucode_done, .ucode_result, .ucode_again, .stage_busy);
    ipc_bus_model bus (.mclk, .resetn, .bus_req, .slow, .bus_addr, .bus_done, .bus_rdata);
    initial forever #5 mclk = ~mclk;
    task automatic chk(input string what, input logic [31:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // decoder and microcode stand-ins; opcode bits: 0 mem, 1 write, 2 repeat
    always @(negedge mclk) begin
        {dec_repeat, dec_need_write, dec_need_mem} <= dec_opcode[2:0];
        dec_mem_addr <= {12'h012, dec_opcode};
        ucode_done <= 1'b0;
        gap <= gap + 1;
        if (!resetn) begin
            {n_exec, uc, rep, pend, saw, ucode_again} <= 0;
            min_gap <= 255;
            gap <= 1000;
        end else begin
            if (bus_req && bus_kind == 2'h0 && stage_busy[3:1] != 3'h0) saw <= 1'b1;
            if (bus_req && bus_kind == 2'h2) begin
                // write only when needed, carrying the result
                chk("write", {pend, bus_wdata}, {1'b1, ucode_result});
                pend <= 1'b0;
            end
            if (ucode_start) begin
                uc <= 2;
                op <= ucode_entry;
                if (!rep && gap < min_gap) min_gap <= gap;
                // earlier write went out first
                if (!rep) chk("pending", pend, 1'b0);
                // operand read before execution
                if (ucode_entry[0]) chk("operand", ucode_operand[7:0], ucode_entry);
            end else if (uc == 1) begin
                ucode_done <= 1'b1;
                ucode_result <= ~ucode_result;
                ucode_again <= op[2] && !rep;
                rep <= op[2] && !rep;
                if (!op[2] || rep) begin
                    n_exec <= n_exec + 1;
                    pend <= op[1];
                    gap <= 0;
                end
            end
            if (uc > 0 && !ucode_start) uc <= uc - 1;
        end
    end
    task automatic t_run(input logic ovl, input logic [7:0] id, input logic sl);
        int k;
        resetn = 0;
        {overlap_disable, idle_count, slow} = {ovl, id, sl};
        repeat (2) @(negedge mclk);
        resetn = 1;
        for (k = 0; k < 9 && !bus_req; k++) @(negedge mclk);
        // first fetch at reset segment and pointer
        chk("fetch", {bus_kind, bus_addr}, {2'h0, 20'hffff0});
        for (k = 0; k < 3000 && n_exec < 12; k++) @(negedge mclk);
        chk("executed", n_exec >= 12, 1'b1);
        // decode and microcode start add at least two cycles beyond the gap
        chk("gap", min_gap >= id + 2, 1'b1);
        // fetch overlaps only when enabled
        chk("overlap", saw, !ovl);
        bus_busy = 1;
        for (k = 0; k < 16; k++) begin
            @(negedge mclk);
            chk("busy", bus_req, 1'b0);
        end
        bus_busy = 0;
        @(negedge mclk);
    endtask
    // overlap on, no gap, quick bus
    task automatic t_overlap_quick;
        t_run(1'b0, 8'h00, 1'b0);
    endtask
    // overlap on, gap of five, slow bus
    task automatic t_overlap_gap_slow;
        t_run(1'b0, 8'h05, 1'b1);
    endtask
    // overlap off, gap of three, quick bus
    task automatic t_serial_gap;
        t_run(1'b1, 8'h03, 1'b0);
    endtask
    // overlap off, no gap, slow bus
    task automatic t_serial_slow;
        t_run(1'b1, 8'h00, 1'b1);
    endtask
    initial begin
        repeat (8) @(negedge mclk);
        resetn = 1;
        // one cycle of traffic, so the first scenario resets in mid-run
        @(negedge mclk);
        t_overlap_quick;
        t_overlap_gap_slow;
        t_serial_gap;
        t_serial_slow;
        tally_and_finish;
    end
    initial begin
        #900000;
        miscompares++;
        tally_and_finish;
    end
endmodule
bind ipc_pipe ipc_monitor mon (.mclk, .resetn, .overlap_disable, .bus_req, .bus_busy,
    .ucode_start, .ucode_done, .ucode_again, .dec_repeat, .bus_kind, .bus_addr,
    .ucode_entry, .dec_opcode, .stage_busy);
`default_nettype wire
